// ==== hdl/pux_pkg.sv ====
// Package: offsets, fields, reset values and carriers of the unit index block
package pux_pkg;
  // ---------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [11:0] OFF_DOM_VER  = 12'h518;
  localparam logic [11:0] OFF_UNIT_SEL = 12'h520;
  localparam logic [11:0] OFF_TRIG_STS = 12'h524;
  localparam logic [11:0] OFF_IDX_LO   = 12'h52c;
  localparam logic [11:0] OFF_IDX_HI   = 12'h5b3;
  localparam logic [11:0] OFF_MSG_CFG  = 12'h600;
  localparam logic [11:0] OFF_IRQ_EN   = 12'h604;
  localparam logic [11:0] OFF_IRQ_CLR  = 12'h608;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int VER_LSB      = 8;
  localparam int VER_MSB      = 11;
  localparam int DOM_MSB      = 7;
  localparam int DOMCHK_BIT   = 4;
  localparam int PIN_BIT      = 16;
  localparam int STAMP_BIT    = 8;
  localparam int TRIG_LSB     = 0;
  localparam int TRIG_MSB     = 1;
  localparam int ERR_LSB      = 16;
  localparam int ERR_MSB      = 18;
  localparam int DONE_MSB     = 2;
  localparam logic [31:0] SEL_RW_MASK = 32'h000f_0f03;
  localparam logic [31:0] STS_MASK    = 32'h0007_0007;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [3:0]  VER_RST    = 4'h2;
  localparam logic [7:0]  DOM_RST    = 8'h00;
  localparam logic [31:0] SEL_RST    = 32'h0000_0000;
  localparam logic [31:0] IRQ_EN_RST = 32'h0007_0007;
  localparam logic [1:0]  TRIG_RSVD  = 2'h3;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       valid;
    logic [3:0] version;
    logic [7:0] domain;
  } pux_msg_t;

  typedef struct packed {
    logic valid;
    logic capture;
    logic to_host;
    logic drop;
  } pux_verdict_t;

  typedef struct packed {
    logic        req;
    logic        write;
    logic [11:0] addr;
    logic [31:0] wdata;
    logic        pin_selector;
    logic        stamp_unit_selector;
    logic [2:0]  trig_unit_onehot;
  } pux_idx_req_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_EXT  = 3'b010,
    ST_DONE = 3'b100
  } pux_state_t;
endpackage : pux_pkg

// ==== hdl/pux_regs.sv ====
// Unit index, domain/version and trigger status registers behind APB
// Functional notes
// R1 - Timing messages are captured only when their version equals the 4-bit version setting, reset 2.
// R2 - Timing packets whose version differs from the setting are dropped.
// R3 - With domain checking on, capture is enabled only when the domain equals the 8-bit setting, reset 0.
// R4 - With domain checking off, the message domain is ignored.
// R5 - With domain checking on, matching messages go to the host port and mismatching ones are dropped.
// R6 - Accesses in the indexed range reach the pin, stamp unit and trigger unit chosen in the select register.
// R7 - The pin selector bit picks the second pin when 1 and the first when 0, reset 0.
// R8 - The stamp unit selector bit picks unit 1 when 1 and unit 0 when 0, reset 0.
// R9 - Trigger selector codes 00, 01, 10 pick units 0, 1, 2; code 11 is reserved and not to be used.
// R10 - A unit's error flag (bits 18..16) sets when notification is on and its trigger time is already past.
// R11 - An error flag clears when the unit's trigger enable is written to zero, or when one is written to it.
// R12 - A unit's done flag (bits 2..0) sets when its trigger output is generated with notification on.
// R13 - Writing one to a done flag clears it; all flags reset to zero.
// R14 - Any set error or done flag raises the host interrupt; here only flags whose bit is set in the interrupt enable register do.
// R15 - Writing zero to a flag leaves it unchanged, and reserved read-only bits read zero.
module pux_regs #(
  parameter int TRIG_UNITS = 3
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic                       pready,
  output logic [31:0]                prdata,
  output logic                       pslverr,
  output pux_pkg::pux_idx_req_t      idx_req,
  input  wire logic                  idx_ack,
  input  wire logic [31:0]           idx_rdata,
  input  wire logic [2:0]            trig_notification_enable,
  input  wire logic [2:0]            trig_late,
  input  wire logic [2:0]            trig_fired,
  input  wire logic [2:0]            trig_en_zeroed,
  input  wire pux_pkg::pux_msg_t     msg_in,
  output pux_pkg::pux_verdict_t      verdict,
  output logic                       irq
);
  // ---------------------------------------------------------------
  // Elaboration check
  // ---------------------------------------------------------------
  // Status layout holds exactly three trigger units
  // Three error bits and three done bits are fixed by the status word layout
  if (TRIG_UNITS != 3) begin : g_bad_units
    $error("pux_regs: TRIG_UNITS must be 3");
  end

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  // Registers and their next values
  pux_pkg::pux_state_t    st_r, st_nxt;
  logic                   pready_r, pready_nxt;
  logic [31:0]            prdata_r, prdata_nxt;
  logic                   pslverr_r, pslverr_nxt;
  logic [3:0]             ver_r, ver_nxt;
  logic [7:0]             dom_r, dom_nxt;
  logic [31:0]            sel_r, sel_nxt;
  logic                   domchk_r, domchk_nxt;
  logic [31:0]            irq_en_r, irq_en_nxt;
  logic [2:0]             err_r, err_nxt;
  logic [2:0]             done_r, done_nxt;
  logic                   irq_r, irq_nxt;
  pux_pkg::pux_idx_req_t  idx_r, idx_nxt;
  pux_pkg::pux_verdict_t  vd_r, vd_nxt;

  // Decode helpers and flag images, all combinational
  logic        acc;
  logic        wr;
  logic        in_idx;
  logic [31:0] rd_local;
  logic        hit;
  logic [31:0] sts_vec;
  logic [2:0]  w1c_err;
  logic [2:0]  w1c_done;
  logic [2:0]  trig_oh;

  // ---------------------------------------------------------------
  // Address decode and read mux
  // ---------------------------------------------------------------
  // A transfer is taken on its first access edge; writes wait for the edge that completes it,
  // so a wait state or a stalled indexed access never commits a register early
  // The index window is a plain range compare, so unaligned addresses inside it pass too
  assign acc    = psel && penable && (st_r == pux_pkg::ST_IDLE);
  assign wr     = psel && penable && pwrite && (st_r == pux_pkg::ST_DONE);
  assign in_idx = (paddr >= pux_pkg::OFF_IDX_LO) && (paddr <= pux_pkg::OFF_IDX_HI); // R6

  // Status image; reserved bits stay zero
  // Built once and shared by the read mux and the interrupt term
  always_comb begin
    sts_vec = '0;
    sts_vec[pux_pkg::ERR_MSB:pux_pkg::ERR_LSB] = err_r;  // R15
    sts_vec[pux_pkg::DONE_MSB:0] = done_r;
  end

  // Local read image; an unmapped offset flags a slave error
  always_comb begin
    rd_local = '0;
    hit      = 1'b1;
    case (paddr)
      pux_pkg::OFF_DOM_VER: begin
        rd_local[pux_pkg::VER_MSB:pux_pkg::VER_LSB] = ver_r;
        rd_local[pux_pkg::DOM_MSB:0] = dom_r;
      end
      pux_pkg::OFF_UNIT_SEL: rd_local = sel_r;
      pux_pkg::OFF_TRIG_STS: rd_local = sts_vec;
      pux_pkg::OFF_MSG_CFG:  rd_local[pux_pkg::DOMCHK_BIT] = domchk_r;
      pux_pkg::OFF_IRQ_EN:   rd_local = irq_en_r;
      pux_pkg::OFF_IRQ_CLR:  rd_local = '0;     // Write-only, reads zero
      default:               hit = 1'b0;
    endcase
  end

  // Trigger selector to one-hot; reserved code reaches no unit
  always_comb begin
    case (sel_r[pux_pkg::TRIG_MSB:pux_pkg::TRIG_LSB])
      2'h0:    trig_oh = 3'h1;                  // R9
      2'h1:    trig_oh = 3'h2;                  // R9
      2'h2:    trig_oh = 3'h4;                  // R9
      default: trig_oh = 3'h0;                  // R9
    endcase
  end

  // ---------------------------------------------------------------
  // APB handshake and indexed forwarding
  // ---------------------------------------------------------------
  // Indexed accesses stall the bus until the unit logic acknowledges
  always_comb begin
    st_nxt      = st_r;
    pready_nxt  = 1'b0;
    prdata_nxt  = prdata_r;
    pslverr_nxt = 1'b0;
    idx_nxt     = idx_r;
    case (st_r)
      pux_pkg::ST_IDLE: begin
        // Selectors are copied with the request, so a later select write cannot redirect it
        if (acc && in_idx) begin
          idx_nxt.req                 = 1'b1;   // R6
          idx_nxt.write               = pwrite;
          idx_nxt.addr                = paddr;
          idx_nxt.wdata               = pwdata;
          idx_nxt.pin_selector        = sel_r[pux_pkg::PIN_BIT];   // R6 R7
          idx_nxt.stamp_unit_selector = sel_r[pux_pkg::STAMP_BIT]; // R6 R8
          idx_nxt.trig_unit_onehot    = trig_oh;                   // R6
          st_nxt                      = pux_pkg::ST_EXT;
        end else if (acc) begin
          pready_nxt  = 1'b1;
          prdata_nxt  = pwrite ? 32'h0000_0000 : rd_local;
          pslverr_nxt = ~hit;
          st_nxt      = pux_pkg::ST_DONE;
        end
      end
      pux_pkg::ST_EXT: begin
        // No timeout: unit logic that never acknowledges keeps the bus stalled
        if (idx_ack) begin
          idx_nxt.req = 1'b0;
          pready_nxt  = 1'b1;
          prdata_nxt  = idx_r.write ? 32'h0000_0000 : idx_rdata;
          st_nxt      = pux_pkg::ST_DONE;
        end
      end
      // One idle cycle after each answer keeps the same transfer from being taken twice
      pux_pkg::ST_DONE: st_nxt = pux_pkg::ST_IDLE;
      // Codes outside the one-hot set fall back to idle
      default:          st_nxt = pux_pkg::ST_IDLE;
    endcase
  end

  // Handshake registers; pready and pslverr stand for exactly one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r      <= pux_pkg::ST_IDLE;
      pready_r  <= 1'b0;
      prdata_r  <= '0;
      pslverr_r <= 1'b0;
      idx_r     <= '0;
    end else begin
      st_r      <= st_nxt;
      pready_r  <= pready_nxt;
      prdata_r  <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
      idx_r     <= idx_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  // Writes commit on the edge at which the master samples pready high
  always_comb begin
    ver_nxt    = ver_r;
    dom_nxt    = dom_r;
    sel_nxt    = sel_r;
    domchk_nxt = domchk_r;
    irq_en_nxt = irq_en_r;
    if (wr && !in_idx) begin
      case (paddr)
        pux_pkg::OFF_DOM_VER: begin
          ver_nxt = pwdata[pux_pkg::VER_MSB:pux_pkg::VER_LSB]; // R1
          dom_nxt = pwdata[pux_pkg::DOM_MSB:0];                // R3
        end
        // Reserved read/write select bits are kept so software reads back what it wrote
        pux_pkg::OFF_UNIT_SEL: sel_nxt = pwdata & pux_pkg::SEL_RW_MASK; // R7 R8 R9
        pux_pkg::OFF_MSG_CFG:  domchk_nxt = pwdata[pux_pkg::DOMCHK_BIT];
        // Enable resets with all six flag bits set so every flag interrupts until software masks it
        pux_pkg::OFF_IRQ_EN:   irq_en_nxt = pwdata & pux_pkg::STS_MASK;
        default: begin
        end
      endcase
    end
  end

  // Configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ver_r    <= pux_pkg::VER_RST;
      dom_r    <= pux_pkg::DOM_RST;
      sel_r    <= pux_pkg::SEL_RST;
      domchk_r <= 1'b0;
      irq_en_r <= pux_pkg::IRQ_EN_RST;
    end else begin
      ver_r    <= ver_nxt;
      dom_r    <= dom_nxt;
      sel_r    <= sel_nxt;
      domchk_r <= domchk_nxt;
      irq_en_r <= irq_en_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Trigger status flags and interrupt
  // ---------------------------------------------------------------
  // Clear through the status word itself or the separate clear word
  // Event inputs come from same-clock unit logic, so they need no synchroniser
  always_comb begin
    w1c_err  = 3'h0;
    w1c_done = 3'h0;
    if (wr && ((paddr == pux_pkg::OFF_TRIG_STS) || (paddr == pux_pkg::OFF_IRQ_CLR))) begin
      w1c_err  = pwdata[pux_pkg::ERR_MSB:pux_pkg::ERR_LSB]; // R11 R15
      w1c_done = pwdata[pux_pkg::DONE_MSB:0];               // R13 R15
    end
  end

  // A new event wins over a clear landing in the same cycle
  always_comb begin
    err_nxt  = (err_r & ~(w1c_err | trig_en_zeroed))
             | (trig_notification_enable & trig_late);             // R10 R11
    done_nxt = (done_r & ~w1c_done)
             | (trig_notification_enable & trig_fired);            // R12 R13
    irq_nxt  = |(sts_vec & irq_en_r);                              // R14
  end

  // Flags and interrupt line; irq trails the flags by one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_r  <= 3'h0;                           // R13
      done_r <= 3'h0;                           // R13
      irq_r  <= 1'b0;
    end else begin
      err_r  <= err_nxt;
      done_r <= done_nxt;
      irq_r  <= irq_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Received message filter
  // ---------------------------------------------------------------
  // One-cycle verdict per message; the limited exception list is not modelled
  // Capture and host forwarding share one decision, traded for a smaller filter
  always_comb begin
    logic ver_ok;
    logic dom_ok;
    ver_ok = (msg_in.version == ver_r);                    // R1 R2
    dom_ok = !domchk_r || (msg_in.domain == dom_r);        // R3 R4
    vd_nxt.valid   = msg_in.valid;
    vd_nxt.capture = msg_in.valid && ver_ok && dom_ok;     // R1 R3 R4
    vd_nxt.to_host = msg_in.valid && ver_ok && dom_ok;     // R5
    vd_nxt.drop    = msg_in.valid && !(ver_ok && dom_ok);  // R2 R5
  end

  // Verdict register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vd_r <= '0;
    end else begin
      vd_r <= vd_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Every port is driven straight from a flip-flop
  assign pready  = pready_r;
  assign prdata  = prdata_r;
  assign pslverr = pslverr_r;
  assign idx_req = idx_r;
  assign verdict = vd_r;
  assign irq     = irq_r;
endmodule : pux_regs

// ==== tb/pux_regs_props.sv ====
// Checker: port-level assertions of the unit index block
module pux_regs_props (
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire pux_pkg::pux_idx_req_t idx_req,
  input wire logic                  idx_ack,
  input wire pux_pkg::pux_msg_t     msg_in,
  input wire pux_pkg::pux_verdict_t verdict,
  input wire logic                  irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // Message verdicts
  // ----------------------------------------
  a_verdict_follows: assert property (msg_in.valid |=> verdict.valid)
    else $error("verdict missing after message");
  a_verdict_cause: assert property (verdict.valid |-> $past(msg_in.valid))
    else $error("verdict without message");
  a_capture_drop: assert property (verdict.valid |-> verdict.capture ^ verdict.drop)
    else $error("capture and drop not exclusive");
  a_host_capture: assert property (verdict.valid |-> verdict.to_host == verdict.capture)
    else $error("host forward differs from capture");
  // ----------------------------------------
  // Indexed accesses and bus answers
  // ----------------------------------------
  a_req_holds: assert property (idx_req.req && !idx_ack |=> idx_req.req)
    else $error("indexed request dropped early");
  a_req_answer: assert property (idx_req.req && idx_ack |=> pready && !idx_req.req)
    else $error("indexed answer late");
  a_unit_onehot: assert property (idx_req.req |-> $countones(idx_req.trig_unit_onehot) <= 1)
    else $error("more than one trigger unit selected");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  // Main scenarios reached
  cover property (verdict.valid && verdict.capture);
  cover property (idx_req.req && idx_ack);
  cover property ($rose(irq));
endmodule : pux_regs_props

bind pux_regs pux_regs_props pux_regs_props_inst (.pclk, .presetn, .pready, .pslverr, .idx_req, .idx_ack,
  .msg_in, .verdict, .irq);

// ==== tb/test_pux_regs.sv ====
// Testbench: APB, indexed access, flag and message filter checks of the unit index block
module test_pux_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  pclk, presetn, psel, penable, pwrite, pready, pslverr, idx_ack, irq;
  logic [11:0]           paddr;
  logic [31:0]           pwdata, prdata, idx_rdata, v, r, wd_exp;
  logic [2:0]            trig_notification_enable, trig_late, trig_fired, trig_en_zeroed;
  logic [17:0]           sel_exp, idx_seen;
  logic [3:0]            ver;
  logic [7:0]            dom;
  logic                  cap;
  pux_pkg::pux_idx_req_t idx_req;
  pux_pkg::pux_msg_t     msg_in;
  pux_pkg::pux_verdict_t verdict;
  logic [32:0]           rd_q[$];
  logic [3:0]            vd_q[$];
  int                    err_total, cmp_count, cycles;
  integer                seed = 55823;

  pux_regs pux_regs_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
    .pslverr, .idx_req, .idx_ack, .idx_rdata, .trig_notification_enable, .trig_late, .trig_fired,
    .trig_en_zeroed, .msg_in, .verdict, .irq);

  // Everything the indexed request carries but the request strobe and the write data, in one word
  assign idx_seen = {idx_req.write, idx_req.addr, idx_req.pin_selector, idx_req.stamp_unit_selector,
                     idx_req.trig_unit_onehot};

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One APB transfer; the answer {pslverr, prdata} is noted for the monitor
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [32:0] exp);
    rd_q.push_back(exp);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic pulse(input logic [2:0] n, input logic [2:0] l, input logic [2:0] f);
    trig_notification_enable <= n;
    trig_late <= l;
    trig_fired <= f;
    @(posedge pclk);
    trig_late <= 3'h0;
    trig_fired <= 3'h0;
    @(posedge pclk);
  endtask : pulse

  // Irq is looked at mid-cycle, then the bench returns to just after a rising edge
  task automatic chk_irq(input logic e);
    @(negedge pclk);
    check(irq, e);
    @(posedge pclk);
  endtask : chk_irq

  task automatic stop_test;
    $display("Comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test

  // Monitor at the falling edge so registered outputs have settled
  always @(negedge pclk) begin
    if (pready === 1'b1) begin
      check({pslverr, prdata}, rd_q.pop_front());
    end
    if (verdict.valid === 1'b1) begin
      check(verdict, vd_q.pop_front());
    end
  end

  // Indexed unit stand-in: acknowledges one cycle after each request
  always @(posedge pclk) begin
    if (idx_req.req === 1'b1 && idx_ack === 1'b0) begin
      check(idx_seen, sel_exp);
      check(idx_req.wdata, wd_exp);
    end
    idx_ack <= idx_req.req && !idx_ack;
  end

  // Hang guard: the sequence needs well under a thousand cycles
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      stop_test();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, idx_rdata, msg_in} = '0;
    {trig_notification_enable, trig_late, trig_fired, trig_en_zeroed} = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, pux_pkg::OFF_DOM_VER, 32'h0, {21'h0, pux_pkg::VER_RST, pux_pkg::DOM_RST});
    apb(1'b0, pux_pkg::OFF_UNIT_SEL, 32'h0, {1'b0, pux_pkg::SEL_RST});
    apb(1'b0, pux_pkg::OFF_TRIG_STS, 32'h0, 33'h0);
    apb(1'b1, 12'h700, 32'h0, {1'b1, 32'h0});
    // Every trigger selector code, random pin and stamp bits, then an indexed read and write
    for (int i = 0; i < 4; i++) begin
      v = ($random(seed) & ~32'h3) | i;
      r = $random(seed);
      apb(1'b1, pux_pkg::OFF_UNIT_SEL, v, 33'h0);
      apb(1'b0, pux_pkg::OFF_UNIT_SEL, 32'h0, {1'b0, v & pux_pkg::SEL_RW_MASK});
      sel_exp <= {1'b0, pux_pkg::OFF_IDX_LO + 12'(4 * i), v[16], v[8], (i == 3) ? 3'b000 : 3'(3'b001 << i)};
      wd_exp <= 32'h0;
      idx_rdata <= r;
      apb(1'b0, pux_pkg::OFF_IDX_LO + 12'(4 * i), 32'h0, {1'b0, r});
      sel_exp[17] <= 1'b1;
      wd_exp <= ~r;
      apb(1'b1, pux_pkg::OFF_IDX_LO + 12'(4 * i), ~r, 33'h0);
    end
    // Flags gated by notification, zero write, one write and enable-zero clears
    pulse(3'b011, 3'b111, 3'b111);
    apb(1'b0, pux_pkg::OFF_TRIG_STS, 32'h0, 33'h0_0003_0003);
    chk_irq(1'b1);
    apb(1'b1, pux_pkg::OFF_TRIG_STS, 32'h0, 33'h0);
    apb(1'b1, pux_pkg::OFF_TRIG_STS, 32'h1, 33'h0);
    trig_en_zeroed <= 3'b010;
    @(posedge pclk);
    trig_en_zeroed <= 3'b000;
    apb(1'b0, pux_pkg::OFF_TRIG_STS, 32'h0, 33'h0_0001_0002);
    apb(1'b1, pux_pkg::OFF_IRQ_CLR, 32'h0001_0002, 33'h0);
    apb(1'b0, pux_pkg::OFF_TRIG_STS, 32'h0, 33'h0);
    chk_irq(1'b0);
    // Masked event keeps the line low until the enable returns
    apb(1'b1, pux_pkg::OFF_IRQ_EN, 32'h0, 33'h0);
    pulse(3'b100, 3'b000, 3'b100);
    chk_irq(1'b0);
    apb(1'b1, pux_pkg::OFF_IRQ_EN, pux_pkg::IRQ_EN_RST, 33'h0);
    apb(1'b0, pux_pkg::OFF_IRQ_EN, 32'h0, {1'b0, pux_pkg::IRQ_EN_RST});
    chk_irq(1'b1);
    apb(1'b1, pux_pkg::OFF_TRIG_STS, 32'h0000_0004, 33'h0);
    // Message filter, domain check off for the first half and on for the second
    apb(1'b1, pux_pkg::OFF_DOM_VER, 32'h0000_053c, 33'h0);
    for (int k = 0; k < 16; k++) begin
      if (k == 8) begin
        apb(1'b1, pux_pkg::OFF_MSG_CFG, 32'h10, 33'h0);
        apb(1'b0, pux_pkg::OFF_MSG_CFG, 32'h0, 33'h10);
      end
      ver = k[0] ? 4'h5 : 4'($random(seed));
      dom = k[1] ? 8'h3c : 8'($random(seed));
      cap = (ver == 4'h5) && (k < 8 || dom == 8'h3c);
      vd_q.push_back({1'b1, cap, cap, !cap});
      msg_in <= {1'b1, ver, dom};
      @(posedge pclk);
      msg_in.valid <= 1'b0;
      @(posedge pclk);
    end
    repeat (4) @(posedge pclk);
    stop_test();
  end
endmodule : test_pux_regs
